/* verilog/csa_slice.sv */
// Purpose: Ten-cell carry-select adder/counter slice with APB registers
// Assumes: Neighbouring logic on pclk drives the cluster carry-in
// Notes: All outputs are flops; combinational results lag one edge
`timescale 1ns/1ps
`include "csa_defines.svh"

module csa_slice import csa_pkg::*; #(
    parameter int N_CELLS = `CSA_N_CELLS,          // Cells per cluster
    parameter int SEG_CELLS = `CSA_SEG_CELLS,      // Cells per carry segment
    parameter bit CHIP_CLEAR_ENABLE = 1'b1         // Build option for chip clear
) (
    input wire logic pclk,                         // Clock, 200 MHz
    input wire logic presetn,                      // Async reset, active low
    input wire logic psel,                         // APB select
    input wire logic penable,                      // APB access phase
    input wire logic pwrite,                       // APB direction
    input wire logic [`CSA_ADDR_W-1:0] paddr,      // APB byte address
    input wire logic [31:0] pwdata,                // APB write data
    output logic [31:0] prdata,                    // APB read data
    output logic pready,                           // APB ready
    output logic pslverr,                          // APB error, unmapped
    input wire logic chip_wide_clear_n,            // Chip clear pin, low
    input wire logic cluster_carry_in,             // Carry from lower cluster
    output logic cluster_carry_out,                // Carry to upper cluster
    output logic [N_CELLS-1:0] cell_reg_out,       // Registered cell outputs
    output logic [N_CELLS-1:0] cell_comb_out       // Unregistered sums, sampled
);

    localparam int IW = $clog2(N_CELLS);           // Chain start index width

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    ////////////////////////////////////////////////////////////////////////

    // Two selection points and a status word of 32 bits
    // Status holds 2*N_CELLS+1 bits
    generate
        if (N_CELLS != 2 * SEG_CELLS || N_CELLS > 10 || SEG_CELLS < 1) begin : g_bad
            $error("csa_slice: N_CELLS must be 2*SEG_CELLS and at most 10");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////

    // Register file
    logic [N_CELLS-1:0] operand_a_in;              // Software operand a
    logic [N_CELLS-1:0] operand_b_in;              // Software operand b
    logic [N_CELLS-1:0] third_data_in;             // Load data per cell
    csa_ctrl_t ctrl;                               // Cluster-wide controls
    logic [IW-1:0] chain_start;                    // First cell of chain

    // Per-cell controls
    logic [N_CELLS-1:0] count_enable;              // Per-cell counter enable
    logic [N_CELLS-1:0] count_up;                  // Per-cell direction
    logic [N_CELLS-1:0] clear_select;              // 1 uses second clear

    // Cell state
    logic [N_CELLS-1:0] cell_reg;                  // Cell registers
    logic [N_CELLS-1:0] next_cell_reg;             // Next cell values

    // Datapath
    logic [N_CELLS-1:0] eff_a;                     // Operand a after mux
    logic [N_CELLS-1:0] eff_b;                     // Operand b after invert

    // Candidate sums
    logic [N_CELLS-1:0] sum_assume_zero;           // Sum with carry zero
    logic [N_CELLS-1:0] sum_assume_one;            // Sum with carry one
    logic [N_CELLS-1:0] sum;                       // Selected sum

    // Carry chains
    logic [N_CELLS-1:0] carry_assume_zero_in;      // Chain zero, into cell
    logic [N_CELLS-1:0] carry_assume_one_in;       // Chain one, into cell
    logic [N_CELLS-1:0] carry_assume_zero_out;     // Chain zero, out of cell
    logic [N_CELLS-1:0] carry_assume_one_out;      // Chain one, out of cell

    // Segment selects
    logic seg_sel_low;                             // Resolved carry, low half
    logic seg_sel_high;                            // Resolved after fifth cell
    logic carry_resolved;                          // Resolved after tenth cell

    // Counter steps
    logic [N_CELLS-1:0] up_word;                   // Register plus one
    logic [N_CELLS-1:0] down_word;                 // Register minus one

    // Chip clear
    logic clr_sync1;                               // Chip clear, first stage
    logic clr_sync2;                               // Chip clear, second stage
    logic chip_clear_act;                          // Chip clear in force

    // Bus decode
    logic setup_phase;                             // APB setup cycle
    logic wr_en;                                   // APB write completes
    logic addr_hit;                                // Address is mapped
    logic [31:0] read_word;                        // Read mux result

    localparam logic [N_CELLS-1:0] ONE_WORD = N_CELLS'(1); // Count step

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    ////////////////////////////////////////////////////////////////////////

    // Ready comes one cycle after setup, so access lasts one cycle
    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    // Map check for the error answer
    always_comb begin
        case (paddr)
            `CSA_OFF_OPERAND_A,
            `CSA_OFF_OPERAND_B,
            `CSA_OFF_THIRD_DATA,
            `CSA_OFF_CTRL,
            `CSA_OFF_CHAIN_START,
            `CSA_OFF_COUNT_EN,
            `CSA_OFF_COUNT_UP,
            `CSA_OFF_CLEAR_SEL,
            `CSA_OFF_STATUS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // Read mux; status shows live cell state
    always_comb begin
        case (paddr)
            `CSA_OFF_OPERAND_A: read_word = 32'(operand_a_in);
            `CSA_OFF_OPERAND_B: read_word = 32'(operand_b_in);
            `CSA_OFF_THIRD_DATA: read_word = 32'(third_data_in);
            `CSA_OFF_CTRL: read_word = 32'(ctrl);
            `CSA_OFF_CHAIN_START: read_word = 32'(chain_start);
            `CSA_OFF_COUNT_EN: read_word = 32'(count_enable);
            `CSA_OFF_COUNT_UP: read_word = 32'(count_up);
            `CSA_OFF_CLEAR_SEL: read_word = 32'(clear_select);
            `CSA_OFF_STATUS: begin
                read_word = 32'(cell_reg);
                read_word[`CSA_STATUS_COMB_LSB +: N_CELLS] = cell_comb_out;
                read_word[`CSA_STATUS_CARRY_BIT] = cluster_carry_out;
            end
            default: read_word = 32'h0000_0000;
        endcase
    end

    // Ready and error answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !addr_hit;
        end
    end

    // Read data captured in setup, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= read_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    ////////////////////////////////////////////////////////////////////////

    // Operand and load data registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand_a_in <= '0;
            operand_b_in <= '0;
            third_data_in <= '0;
        end else if (wr_en) begin
            if (paddr == `CSA_OFF_OPERAND_A) operand_a_in <= pwdata[N_CELLS-1:0];
            if (paddr == `CSA_OFF_OPERAND_B) operand_b_in <= pwdata[N_CELLS-1:0];
            if (paddr == `CSA_OFF_THIRD_DATA) third_data_in <= pwdata[N_CELLS-1:0];
        end
    end

    // Cluster-wide controls, one copy for all cells
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= csa_ctrl_t'(`CSA_CTRL_RESET);
        end else if (wr_en && paddr == `CSA_OFF_CTRL) begin
            ctrl <= csa_ctrl_t'(pwdata[8:0]);
        end
    end

    // Chain start; a position past the last cell is refused
    // A refused write keeps the old start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_start <= '0;
        end else if (wr_en && paddr == `CSA_OFF_CHAIN_START) begin
            if (pwdata < 32'(N_CELLS)) begin
                chain_start <= pwdata[IW-1:0];
            end
        end
    end

    // Per-cell counter and clear selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_enable <= '0;
            count_up <= '0;
            clear_select <= '0;
        end else if (wr_en) begin
            if (paddr == `CSA_OFF_COUNT_EN) count_enable <= pwdata[N_CELLS-1:0];
            if (paddr == `CSA_OFF_COUNT_UP) count_up <= pwdata[N_CELLS-1:0];
            if (paddr == `CSA_OFF_CLEAR_SEL) clear_select <= pwdata[N_CELLS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chip-wide clear pin
    ////////////////////////////////////////////////////////////////////////

    // Two-stage synchroniser; pin is asynchronous to pclk
    // Resets high: no false clear at release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_sync1 <= 1'b1;
            clr_sync2 <= 1'b1;
        end else begin
            clr_sync1 <= chip_wide_clear_n;
            clr_sync2 <= clr_sync1;
        end
    end

    // Ignored entirely unless the build option is set
    assign chip_clear_act = CHIP_CLEAR_ENABLE && !clr_sync2;

    ////////////////////////////////////////////////////////////////////////
    // Carry-select datapath
    ////////////////////////////////////////////////////////////////////////

    // Accumulator feeds register back as operand a
    assign eff_a = ctrl.accumulate ? cell_reg : operand_a_in;

    // Two's complement: invert every b bit
    assign eff_b = ctrl.sub ? ~operand_b_in : operand_b_in;

    // Low half picks with the cluster carry, high half with regenerated carry
    assign seg_sel_low = cluster_carry_in;
    assign seg_sel_high = seg_sel_low ? carry_assume_one_out[SEG_CELLS-1] :
                                        carry_assume_zero_out[SEG_CELLS-1];
    assign carry_resolved = seg_sel_high ? carry_assume_one_out[N_CELLS-1] :
                                           carry_assume_zero_out[N_CELLS-1];

    generate
        for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
            localparam logic [IW-1:0] POS = IW'(i); // Cell position
            logic at_start;                         // Chain begins here
            logic prev_zero;                        // Chain zero from below
            logic prev_one;                         // Chain one from below
            logic sel;                              // Resolved chain select
            logic clr_hit;                          // Chosen async clear

            assign at_start = (chain_start == POS);

            // Segments restart with assumed carries; cells pass both forward
            if (i == 0 || i == SEG_CELLS) begin : g_head
                assign prev_zero = 1'b0;
                assign prev_one = 1'b1;
            end else begin : g_link
                assign prev_zero = carry_assume_zero_out[i-1];
                assign prev_one = carry_assume_one_out[i-1];
            end

            // At the chain's first cell the subtract select is the carry;
            // at cell 0 the add case still takes the lower cluster's carry
            always_comb begin
                if (at_start && chain_start == '0) begin
                    carry_assume_zero_in[i] = ctrl.sub;
                    carry_assume_one_in[i] = 1'b1;
                end else if (at_start) begin
                    carry_assume_zero_in[i] = ctrl.sub;
                    carry_assume_one_in[i] = ctrl.sub;
                end else begin
                    carry_assume_zero_in[i] = prev_zero;
                    carry_assume_one_in[i] = prev_one;
                end
            end

            // Both sums in parallel
            assign sum_assume_zero[i] = eff_a[i] ^ eff_b[i] ^ carry_assume_zero_in[i];
            assign sum_assume_one[i] = eff_a[i] ^ eff_b[i] ^ carry_assume_one_in[i];

            // Each chain's carry selects between generate and propagate
            assign carry_assume_zero_out[i] = carry_assume_zero_in[i] ?
                (eff_a[i] | eff_b[i]) : (eff_a[i] & eff_b[i]);
            assign carry_assume_one_out[i] = carry_assume_one_in[i] ?
                (eff_a[i] | eff_b[i]) : (eff_a[i] & eff_b[i]);

            // Resolved chain picks the sum
            assign sel = (i < SEG_CELLS) ? seg_sel_low : seg_sel_high;
            assign sum[i] = sel ? sum_assume_one[i] : sum_assume_zero[i];

            // Each cell follows one of the two shared clears
            assign clr_hit = clear_select[i] ? ctrl.async_clear_two : ctrl.async_clear_one;

            // Priority: chip clear, async clear, async load, enable, sync
            // Async controls wait for the edge
            always_comb begin
                if (chip_clear_act) begin
                    next_cell_reg[i] = 1'b0;
                end else if (clr_hit) begin
                    next_cell_reg[i] = 1'b0;
                end else if (ctrl.async_preload) begin
                    next_cell_reg[i] = third_data_in[i];
                end else if (!ctrl.clock_enable) begin
                    next_cell_reg[i] = cell_reg[i];
                end else if (ctrl.sync_clear) begin
                    next_cell_reg[i] = 1'b0;
                end else if (ctrl.sync_load) begin
                    next_cell_reg[i] = third_data_in[i];
                end else if (count_enable[i]) begin
                    next_cell_reg[i] = count_up[i] ? up_word[i] : down_word[i];
                end else begin
                    next_cell_reg[i] = sum[i];
                end
            end
        end
    endgenerate

    // Counter words, one step either way
    assign up_word = cell_reg + ONE_WORD;
    assign down_word = cell_reg - ONE_WORD;

    ////////////////////////////////////////////////////////////////////////
    // Cell registers and outputs
    ////////////////////////////////////////////////////////////////////////

    // Cell registers; every cluster control except bypass acts here together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_reg <= '0;
        end else begin
            cell_reg <= next_cell_reg;
        end
    end

    // Registered output shadows the register, or the sum when bypassed and no chip clear is in force
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_reg_out <= '0;
        end else if (ctrl.bypass && !chip_clear_act) begin
            cell_reg_out <= sum;
        end else begin
            cell_reg_out <= next_cell_reg;
        end
    end

    // Unregistered result, sampled so the port is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_comb_out <= '0;
        end else begin
            cell_comb_out <= sum;
        end
    end

    // Final carry into a flop for general routing and the next cluster
    // Next cluster sees it one edge late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cluster_carry_out <= 1'b0;
        end else begin
            cluster_carry_out <= carry_resolved;
        end
    end

endmodule // csa_slice

/* shared/csa_defines.svh */
// Purpose: Constants of the ten-cell carry-select arithmetic slice
// Assumes: APB register window, 32-bit data, byte addresses
// Notes: Overview list below; offsets are byte addresses
`ifndef CSA_DEFINES_SVH
`define CSA_DEFINES_SVH

`define CSA_N_CELLS 10
`define CSA_SEG_CELLS 5
`define CSA_ADDR_W 12

`define CSA_OFF_OPERAND_A 12'h000
`define CSA_OFF_OPERAND_B 12'h004
`define CSA_OFF_THIRD_DATA 12'h008
`define CSA_OFF_CTRL 12'h00C
`define CSA_OFF_CHAIN_START 12'h010
`define CSA_OFF_COUNT_EN 12'h014
`define CSA_OFF_COUNT_UP 12'h018
`define CSA_OFF_CLEAR_SEL 12'h01C
`define CSA_OFF_STATUS 12'h020

`define CSA_CTRL_RESET 9'h008
`define CSA_STATUS_COMB_LSB 10
`define CSA_STATUS_CARRY_BIT 20

`endif

/* shared/csa_pkg.sv */
// Purpose: Types of the carry-select arithmetic slice
// Assumes: Constants come from csa_defines.svh
// Notes: Control word travels as one packed struct
package csa_pkg;

    // Cluster-wide control word, bit 0 is sub
    typedef struct packed {
        logic accumulate;      // Bit 8: operand a from register
        logic bypass;          // Bit 7: outputs show plain sum
        logic async_preload;   // Bit 6: load third data
        logic async_clear_two; // Bit 5: second clear
        logic async_clear_one; // Bit 4: first clear
        logic clock_enable;    // Bit 3: cluster clock enable
        logic sync_load;       // Bit 2: synchronous load
        logic sync_clear;      // Bit 1: synchronous clear
        logic sub;             // Bit 0: 1 subtract, 0 add
    } csa_ctrl_t;

endpackage

/* verif/csa_slice_properties.sv */
// Purpose: Port-level properties of the arithmetic slice
// Assumes: One clock, presetn async active low
// Notes: Cell registers are hidden, so bus and clear paths are watched
`timescale 1ns/1ps
`include "csa_defines.svh"
module csa_checker import csa_pkg::*; #(
    parameter int N_CELLS = 10, // Cells
    parameter int SEG_CELLS = 5, // Segment
    parameter bit CHIP_CLEAR_ENABLE = 1'b1 // Build option
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Direction
    input wire logic [`CSA_ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic chip_wide_clear_n, // Chip clear
    input wire logic cluster_carry_in, // Carry in
    input wire logic cluster_carry_out, // Carry out
    input wire logic [N_CELLS-1:0] cell_reg_out, // Registered
    input wire logic [N_CELLS-1:0] cell_comb_out // Unregistered
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // Bus answers exactly one cycle after setup
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready too long");
    a_ready_needs_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    // Words past the status word are unmapped
    a_unmapped_error: assert property (psel && !penable && paddr > 12'h020 |=> pslverr)
        else $error("no error on unmapped");
    a_mapped_no_error: assert property (psel && !penable && paddr <= 12'h020 && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("error on mapped");
    // Read data only moves after a read setup
    a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata moved");
    a_reset_outputs_zero: assert property ($rose(presetn) |-> cell_reg_out == '0 && cell_comb_out == '0 && !pready)
        else $error("outputs not cleared");
    // Two sync flops, then every register forced low
    a_chip_clear_zero: assert property ((CHIP_CLEAR_ENABLE && !chip_wide_clear_n) [*4] |=> cell_reg_out == '0)
        else $error("chip clear ignored");
endmodule // csa_checker

/* verif/csa_lower_cluster.sv */
// Purpose: Lower neighbour cluster feeding the carry-in
// Assumes: Same clock as the slice
// Notes: Carry level is picked by the bench
`timescale 1ns/1ps
module csa_lower_cluster (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic next_carry, // Wanted carry
    output logic carry_out // Registered carry
);
    // A cluster carry-out leaves its own flop after the carry chain, so it moves on edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_out <= 1'b0;
        end else begin
            carry_out <= next_carry;
        end
    end
endmodule // csa_lower_cluster

/* verif/tb.sv */
// Purpose: Self-checking bench of the arithmetic slice
// Assumes: Register map and zero-wait access of the slice
// Notes: Seeded random operands with corner cases first
`timescale 1ns/1ps
`include "csa_defines.svh"
module tb import csa_pkg::*;;
    localparam logic [9:0] SUB = 10'h001, SCLR = 10'h002, SLD = 10'h004, CE = 10'h008, CLR1 = 10'h010;
    localparam logic [9:0] CLR2 = 10'h020, PRE = 10'h040, BYP = 10'h080, ACC = 10'h100;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, chip_wide_clear_n = 1, want_carry = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, carry_in, cluster_carry_out, sub;
    logic [9:0] cell_reg_out, cell_comb_out, a, b, t, m, v0, kept_out;
    logic [10:0] e;
    logic [3:0] s;
    int fails = 0, checks_done = 0, seed = 83;
    csa_slice csa_slice_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .chip_wide_clear_n, .cluster_carry_in(carry_in), .cluster_carry_out, .cell_reg_out, .cell_comb_out);
    csa_lower_cluster csa_lower_cluster_i (.pclk, .presetn, .next_carry(want_carry), .carry_out(carry_in));
    // Twin without chip clear
    if (1'b1) begin : g_keep
        csa_slice #(.CHIP_CLEAR_ENABLE(1'b0)) csa_slice_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
            .pwdata, .prdata(), .pready(), .pslverr(), .chip_wide_clear_n, .cluster_carry_in(carry_in),
            .cluster_carry_out(), .cell_reg_out(kept_out), .cell_comb_out());
    end
    always #2.5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t cell got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t bus got %h exp %h", $time, got, exp);
        end
    endtask
    // Setup, then hold everything until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [9:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            $display("MISMATCH %0t apb timeout", $time);
            fails++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Operands need one edge to reach the outputs; two spare
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask
    // Carry-select sum; a chain starting above cell 0 takes sub as carry
    function automatic logic [10:0] exp_sum(input logic [9:0] x, y, input logic sb, ci, input logic [3:0] st);
        logic [10:0] bx;
        logic [10:0] r;
        bx = {1'b0, sb ? ~y : y};
        r = ({1'b0, x} >> st) + (bx >> st) + {10'h000, (st == 4'h0 && !sb) ? ci : sb};
        return r << st;
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i <= 8; i++) begin
            apb(1'b0, 12'(4 * i), 10'h000);
            chk_bus(rd, (i == 3) ? 32'h0000_0008 : 32'h0000_0000);
        end
        apb(1'b0, 12'h024, 10'h000);
        chk_bus({31'h0000_0000, err}, 32'h0000_0001);
        // Random sums and differences, chains at odd starts too
        for (int i = 0; i < 24; i++) begin
            a = 10'($random(seed));
            b = (i == 1) ? a : 10'($random(seed));
            sub = (i == 1) ? 1'b1 : 1'($random(seed));
            s = (i % 3 == 2) ? 4'(1 + {$random(seed)} % 9) : 4'h0;
            want_carry <= (i == 0) ? 1'b1 : 1'($random(seed));
            if (i == 0) begin
                a = 10'h3FF;
                b = 10'h001;
                sub = 1'b0;
            end
            apb(1'b1, `CSA_OFF_OPERAND_A, a);
            apb(1'b1, `CSA_OFF_OPERAND_B, b);
            apb(1'b1, `CSA_OFF_CHAIN_START, {6'h00, s});
            apb(1'b1, `CSA_OFF_CTRL, CE | (sub ? SUB : 10'h000));
            settle();
            e = exp_sum(a, b, sub, want_carry, s);
            m = 10'h3FF << s;
            chk({cluster_carry_out, cell_comb_out & m}, {e[10], e[9:0] & m});
            chk({1'b0, cell_reg_out & m}, {1'b0, e[9:0] & m});
        end
        want_carry <= 1'b0;
        apb(1'b1, `CSA_OFF_CHAIN_START, 10'h000);
        // Cluster-wide load, hold with enable off, clear beats load
        t = 10'($random(seed));
        apb(1'b1, `CSA_OFF_THIRD_DATA, t);
        apb(1'b1, `CSA_OFF_CTRL, CE | SLD);
        settle();
        chk({1'b0, cell_reg_out}, {1'b0, t});
        apb(1'b1, `CSA_OFF_CTRL, SLD);
        apb(1'b1, `CSA_OFF_THIRD_DATA, ~t);
        settle();
        chk({1'b0, cell_reg_out}, {1'b0, t});
        apb(1'b1, `CSA_OFF_CTRL, CE | SCLR | SLD);
        settle();
        chk({1'b0, cell_reg_out}, 11'h000);
        // Counting up, then down
        apb(1'b1, `CSA_OFF_COUNT_EN, 10'h3FF);
        apb(1'b1, `CSA_OFF_CTRL, CE);
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, `CSA_OFF_COUNT_UP, (d == 0) ? 10'h3FF : 10'h000);
            settle();
            v0 = cell_reg_out;
            @(posedge pclk);
            #1;
            chk({1'b0, cell_reg_out}, {1'b0, (d == 0) ? v0 + 10'h001 : v0 - 10'h001});
        end
        apb(1'b1, `CSA_OFF_COUNT_EN, 10'h000);
        // Accumulator adds operand b every edge
        apb(1'b1, `CSA_OFF_CTRL, CE | ACC);
        settle();
        v0 = cell_reg_out;
        @(posedge pclk);
        #1;
        chk({1'b0, cell_reg_out}, {1'b0, v0 + b});
        // Bypass shows the sum while the register is cleared
        apb(1'b1, `CSA_OFF_CTRL, CE | BYP | SCLR);
        settle();
        e = exp_sum(a, b, 1'b0, 1'b0, 4'h0);
        chk({1'b0, cell_reg_out}, {1'b0, e[9:0]});
        apb(1'b0, `CSA_OFF_STATUS, 10'h000);
        chk_bus(rd & 32'h0000_03FF, 32'h0000_0000);
        // Preset, split clears, then chip clear over preset
        apb(1'b1, `CSA_OFF_THIRD_DATA, 10'h3FF);
        apb(1'b1, `CSA_OFF_CTRL, PRE);
        settle();
        chk({1'b0, cell_reg_out}, 11'h3FF);
        m = 10'($random(seed));
        apb(1'b1, `CSA_OFF_CLEAR_SEL, m);
        apb(1'b1, `CSA_OFF_CTRL, PRE | CLR1);
        settle();
        chk({1'b0, cell_reg_out}, {1'b0, m});
        apb(1'b1, `CSA_OFF_CTRL, PRE | CLR2);
        settle();
        chk({1'b0, cell_reg_out}, {1'b0, ~m});
        apb(1'b1, `CSA_OFF_CTRL, PRE);
        chip_wide_clear_n <= 1'b0;
        repeat (6) @(posedge pclk);
        #1;
        chk({1'b0, cell_reg_out}, 11'h000);
        chk({1'b0, kept_out}, 11'h3FF);
        @(posedge pclk);
        chip_wide_clear_n <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        chk({1'b0, cell_reg_out}, 11'h3FF);
        report_and_stop();
    end
endmodule // tb
bind csa_slice csa_checker #(.N_CELLS(N_CELLS), .SEG_CELLS(SEG_CELLS), .CHIP_CLEAR_ENABLE(CHIP_CLEAR_ENABLE))
    csa_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .chip_wide_clear_n, .cluster_carry_in, .cluster_carry_out, .cell_reg_out, .cell_comb_out);
